// [bench/bit_shift_flag_exec_unit_bench.sv]
// Purpose: Self-checking bench for the bit, shift and flag unit
// Assumes: bready and rready held high, full write strobes
// Notes: Expected values are worked out here, never read back
`timescale 1ns/100ps
module bit_shift_flag_exec_unit_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, status_flags;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [7:0] e;
  int errors = 0, compares = 0, n;
  bit_shift_flag_exec_unit u_dut (.*);
  always #2 aclk = ~aclk;
  // ==========================================================
  // Bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, r);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    q = s_axi_rdata;
    rr = s_axi_rresp;
  endtask : rd
  // Counts edges until busy is seen low after the write answer
  task automatic run(input logic [4:0] op, input logic [2:0] i, input logic [2:0] io, int c);
    wr(8'h00, {13'h0000, io, 5'h00, i, 3'h0, op}, 2'h0);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (busy);
    chk(n, c);
  endtask : run
  task automatic ft(input logic [4:0] s, input logic [2:0] i, input int b);
    wr(8'h0c, 32'h0, 2'h0);
    run(s, i, 3'h0, 1);
    rd(8'h0c);
    chk(q, 32'h1 << b);
    chk({24'h0, status_flags}, 32'h1 << b);
    wr(8'h0c, 32'hff, 2'h0);
    run(s + 5'h01, i, 3'h0, 1);
    rd(8'h0c);
    chk(q, 32'hff ^ (32'h1 << b));
    chk({24'h0, status_flags}, 32'hff ^ (32'h1 << b));
  endtask : ft
  task automatic close_out;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // ==========================================================
  // Tests
  initial begin
    int bt[7] = '{0, 2, 1, 7, 4, 3, 6};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Operand 0x96 with carry in set; shifted-out bit lands in carry
    for (int k = 3; k <= 8; k++) begin
      wr(8'h04, 32'h96, 2'h0);
      wr(8'h0c, 32'h01, 2'h0);
      run(5'(k), 3'h0, 3'h0, 1);
      case (k)
        3: e = 8'h2c;
        4: e = 8'h4b;
        5: e = 8'h2d;
        6, 7: e = 8'hcb;
        default: e = 8'h69;
      endcase
      rd(8'h04);
      chk(q, {24'h0, e});
      rd(8'h0c);
      chk(q, {31'h0, k == 3 || k == 5 || k == 8});
    end
    for (int b = 0; b < 8; b++) begin
      ft(5'h09, 3'(b), b);
      wr(8'h08, 32'ha5, 2'h0);
      wr(8'h0c, 32'h0, 2'h0);
      run(5'h0b, 3'(b), 3'h0, 1);
      rd(8'h0c);
      chk(q, ((32'ha5 >> b) & 32'h1) << 6);
      wr(8'h04, 32'hf0, 2'h0);
      wr(8'h0c, 32'h40, 2'h0);
      run(5'h0c, 3'(b), 3'h0, 1);
      rd(8'h04);
      chk(q, 32'hf0 | (32'h1 << b));
    end
    for (int j = 0; j < 7; j++) ft(5'(13 + 2 * j), 3'h0, bt[j]);
    // I/O ops need a read cycle and a write cycle
    wr(8'h2c, 32'h5a, 2'h0);
    run(5'h01, 3'h0, 3'h3, 2);
    rd(8'h2c);
    chk(q, 32'h5b);
    run(5'h02, 3'h6, 3'h3, 2);
    rd(8'h2c);
    chk(q, 32'h1b);
    rd(8'h28);
    chk(q, 32'h0);
    wr(8'h14, 32'hff, 2'h3);
    rd(8'h40);
    chk({rr, q[29:0]}, 32'hc0000000);
    rd(8'h10);
    chk(q, 32'h0);
    rd(8'h00);
    chk(q, 32'h0003_0602);
    // Reset while idle must clear the destination operand, flags and I/O bytes
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({23'h0, busy, status_flags}, 32'h0);
    rd(8'h04);
    chk(q, 32'h0);
    rd(8'h0c);
    chk(q, 32'h0);
    rd(8'h2c);
    chk(q, 32'h0);
    close_out;
  end
  initial begin
    #40000;
    errors++;
    close_out;
  end
endmodule : bit_shift_flag_exec_unit_bench

// [verilog/bit_exec_pkg.sv]
// Purpose: Shared constants and types for the bit, shift and flag unit
// Assumes: 32-bit AXI4-Lite register access, 8-bit datapath
// Notes: Flag positions follow the status byte layout I T H S V N Z C
package bit_exec_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_DEST = 8'h04;
  localparam logic [7:0] OFS_SRC = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_IO_BASE = 8'h20;
  localparam logic [7:0] OFS_IO_LAST = 8'h3c;
  // ==========================================================
  // Command field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_IDX_LSB = 8;
  localparam int CMD_IO_LSB = 16;
  localparam int IO_AW = 3;
  // ==========================================================
  // Reset values
  localparam logic [7:0] DEST_RST = 8'h00;
  localparam logic [7:0] SRC_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] IO_RST = 8'h00;
  // ==========================================================
  // Status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  // ==========================================================
  // Timing and bus answers
  localparam int REG_OP_CYCLES = 1;
  localparam int IO_OP_CYCLES = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ==========================================================
  // Operations and sequencer states
  typedef enum logic [4:0] {
    no_op = 5'h00, io_bit_set_op = 5'h01, io_bit_clear_op = 5'h02,
    logical_left_shift_op = 5'h03, logical_right_shift_op = 5'h04,
    rotate_left_carry_op = 5'h05, rotate_right_carry_op = 5'h06,
    arith_right_shift_op = 5'h07, nibble_swap_op = 5'h08,
    generic_flag_set_op = 5'h09, generic_flag_clear_op = 5'h0a,
    bit_to_transfer_flag_op = 5'h0b, transfer_flag_to_bit_op = 5'h0c,
    carry_set_op = 5'h0d, carry_clear_op = 5'h0e, negative_set_op = 5'h0f,
    negative_clear_op = 5'h10, zero_set_op = 5'h11, zero_clear_op = 5'h12,
    irq_enable_op = 5'h13, irq_disable_op = 5'h14, signed_flag_set_op = 5'h15,
    signed_flag_clear_op = 5'h16, overflow_set_op = 5'h17,
    overflow_clear_op = 5'h18, transfer_flag_set_op = 5'h19,
    transfer_flag_clear_op = 5'h1a
  } op_e;
  typedef struct packed {
    logic [IO_AW-1:0] io_addr;
    logic [2:0] bit_idx;
    op_e op;
  } cmd_s;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_exec = 2'b01,
    st_io_write = 2'b10
  } seq_e;
endpackage : bit_exec_pkg

// [verilog/bit_shift_flag_exec_unit.sv]
// Purpose: Bit, shift and flag execution unit behind an AXI4-Lite slave
// Assumes: One clock, synchronous active-low reset, one command at a time
// Notes: Mapped writes while a command runs are refused with SLVERR
`timescale 1ns/100ps
// What this block does
// - A logical left shift moves every bit up one place and puts zero in bit 0.
// - A logical right shift moves every bit down one place and puts zero in bit 7.
// - Rotate left through carry puts old carry in bit 0, shifts up, and bit 7 into carry.
// - Rotate right through carry puts old carry in bit 7, shifts down, and bit 0 into carry.
// - An arithmetic right shift moves bits 7..1 into 6..0 and keeps the sign bit.
// - A nibble swap exchanges the low and high four bits in one operation.
// - Generic flag set and clear write one or zero to the flag picked by the index.
// - Bit store copies the chosen source bit into the transfer flag.
// - Bit load copies the transfer flag into the chosen destination bit only.
// - I/O bit set and clear change only the addressed bit and take two cycles.
// - Dedicated operations force carry or negative alone to one or zero.
// - Dedicated operations force zero alone; register operations finish in one cycle.
// - Interrupt enable sets the interrupt flag and disable clears it.
// - Dedicated operations set or clear signed and overflow flags independently.
// - Dedicated operations force the transfer flag to one or zero.
module bit_shift_flag_exec_unit #(
  parameter int ADDR_W = 8,
  parameter int IO_REGS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] status_flags,
  output logic busy
);
  // ==========================================================
  // State
  bit_exec_pkg::seq_e state_r;
  bit_exec_pkg::seq_e state_nxt;
  bit_exec_pkg::cmd_s cmd_r;
  logic [7:0] dest_r;
  logic [7:0] source_reg_r;
  logic [7:0] status_flags_reg_r;
  logic [7:0] io_tmp_r;
  logic [7:0] io_r [IO_REGS];
  logic busy_r;
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  // ==========================================================
  // Decode signals
  logic wr_fire;
  logic [31:0] wd;
  logic [7:0] waddr;
  logic [7:0] raddr;
  logic wr_cmd;
  logic wr_dest;
  logic wr_src;
  logic wr_flags;
  logic wr_io;
  logic wr_map;
  logic wr_ok;
  localparam int IO_AW_L = bit_exec_pkg::IO_AW;
  logic [IO_AW_L-1:0] wr_idx;
  logic [IO_AW_L-1:0] rd_idx;
  logic [31:0] rd_mux;
  logic [1:0] rd_resp;
  logic exec_now;
  logic io_op;
  logic io_in_range;
  logic [7:0] bit_mask;
  logic [7:0] io_mod;
  logic [7:0] shift_rd;
  logic [7:0] shift_flags;
  logic [7:0] final_flags;

  // ==========================================================
  // Datapath units
  shift_rotate_unit u_shift (
    .op(cmd_r.op),
    .bit_idx(cmd_r.bit_idx),
    .rd(dest_r),
    .flags_in(status_flags_reg_r),
    .rd_out(shift_rd),
    .flags_out(shift_flags)
  );

  flag_op_unit u_flag (
    .op(cmd_r.op),
    .bit_idx(cmd_r.bit_idx),
    .src(source_reg_r),
    .flags_in(shift_flags),
    .flags_out(final_flags)
  );

  // ==========================================================
  // Write address and data capture, either order
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign waddr = 8'(awaddr_r);
  assign raddr = 8'(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && awready_r) begin
      aw_held_r <= 1'b1;
      awready_r <= 1'b0;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end else if (!aw_held_r && !bvalid_r) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && wready_r) begin
      w_held_r <= 1'b1;
      wready_r <= 1'b0;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end else if (!w_held_r && !bvalid_r) begin
      wready_r <= 1'b1;
    end
  end

  // Lanes without a strobe read as zero
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wd[8*i +: 8] = wstrb_r[i] ? wdata_r[8*i +: 8] : 8'h00;
    end
  end

  // ==========================================================
  // Write decode
  always_comb begin
    wr_cmd = 1'b0;
    wr_dest = 1'b0;
    wr_src = 1'b0;
    wr_flags = 1'b0;
    wr_io = 1'b0;
    wr_idx = waddr[2 +: IO_AW_L];
    if (waddr == bit_exec_pkg::OFS_CMD) begin
      wr_cmd = 1'b1;
    end else if (waddr == bit_exec_pkg::OFS_DEST) begin
      wr_dest = 1'b1;
    end else if (waddr == bit_exec_pkg::OFS_SRC) begin
      wr_src = 1'b1;
    end else if (waddr == bit_exec_pkg::OFS_FLAGS) begin
      wr_flags = 1'b1;
    end else if (waddr >= bit_exec_pkg::OFS_IO_BASE && waddr <= bit_exec_pkg::OFS_IO_LAST
                 && waddr[1:0] == 2'h0 && 32'(wr_idx) < IO_REGS) begin
      wr_io = 1'b1;
    end
  end
  assign wr_map = wr_cmd || wr_dest || wr_src || wr_flags || wr_io;
  // Refusing writes while busy keeps the operands stable mid-operation
  assign wr_ok = wr_fire && wr_map && state_r == bit_exec_pkg::st_idle;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= bit_exec_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      if (!wr_map) begin
        bresp_r <= bit_exec_pkg::RESP_DECERR;
      end else if (state_r != bit_exec_pkg::st_idle) begin
        bresp_r <= bit_exec_pkg::RESP_SLVERR;
      end else begin
        bresp_r <= bit_exec_pkg::RESP_OKAY;
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Read path
  assign rd_idx = raddr[2 +: IO_AW_L];
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_resp = bit_exec_pkg::RESP_OKAY;
    if (raddr == bit_exec_pkg::OFS_CMD) begin
      rd_mux = {13'h0, cmd_r.io_addr, 5'h00, cmd_r.bit_idx, 3'h0, cmd_r.op};
    end else if (raddr == bit_exec_pkg::OFS_DEST) begin
      rd_mux = {24'h00_0000, dest_r};
    end else if (raddr == bit_exec_pkg::OFS_SRC) begin
      rd_mux = {24'h00_0000, source_reg_r};
    end else if (raddr == bit_exec_pkg::OFS_FLAGS) begin
      rd_mux = {24'h00_0000, status_flags_reg_r};
    end else if (raddr == bit_exec_pkg::OFS_STAT) begin
      rd_mux = {29'h0000_0000, state_r, busy_r};
    end else if (raddr >= bit_exec_pkg::OFS_IO_BASE && raddr <= bit_exec_pkg::OFS_IO_LAST
                 && raddr[1:0] == 2'h0 && 32'(rd_idx) < IO_REGS) begin
      rd_mux = {24'h00_0000, io_r[rd_idx]};
    end else begin
      rd_resp = bit_exec_pkg::RESP_DECERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= bit_exec_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_resp;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end else if (!rvalid_r && !arready_r) begin
      arready_r <= 1'b1;
    end
  end

  // ==========================================================
  // Command sequencer
  assign exec_now = state_r == bit_exec_pkg::st_exec;
  assign io_op = cmd_r.op == bit_exec_pkg::io_bit_set_op
                 || cmd_r.op == bit_exec_pkg::io_bit_clear_op;
  assign io_in_range = 32'(cmd_r.io_addr) < IO_REGS;
  assign bit_mask = 8'h01 << cmd_r.bit_idx;
  // Read in the first cycle, modified byte written in the second
  assign io_mod = (cmd_r.op == bit_exec_pkg::io_bit_set_op) ? (io_tmp_r | bit_mask)
                  : (io_tmp_r & ~bit_mask);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bit_exec_pkg::st_idle: begin
        if (wr_ok && wr_cmd) begin
          state_nxt = bit_exec_pkg::st_exec;
        end
      end
      bit_exec_pkg::st_exec: begin
        if (io_op && io_in_range) begin
          state_nxt = bit_exec_pkg::st_io_write;
        end else begin
          state_nxt = bit_exec_pkg::st_idle;
        end
      end
      bit_exec_pkg::st_io_write: state_nxt = bit_exec_pkg::st_idle;
      default: state_nxt = bit_exec_pkg::st_idle;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= bit_exec_pkg::st_idle;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= state_nxt != bit_exec_pkg::st_idle;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= '0;
    end else if (wr_ok && wr_cmd) begin
      cmd_r.op <= bit_exec_pkg::op_e'(wd[bit_exec_pkg::CMD_OP_LSB +: 5]);
      cmd_r.bit_idx <= wd[bit_exec_pkg::CMD_IDX_LSB +: 3];
      cmd_r.io_addr <= wd[bit_exec_pkg::CMD_IO_LSB +: IO_AW_L];
    end
  end

  // ==========================================================
  // Working registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dest_r <= bit_exec_pkg::DEST_RST;
    end else if (exec_now) begin
      dest_r <= shift_rd;
    end else if (wr_ok && wr_dest) begin
      dest_r <= wd[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_reg_r <= bit_exec_pkg::SRC_RST;
    end else if (wr_ok && wr_src) begin
      source_reg_r <= wd[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_flags_reg_r <= bit_exec_pkg::FLAGS_RST;
    end else if (exec_now) begin
      status_flags_reg_r <= final_flags;
    end else if (wr_ok && wr_flags) begin
      status_flags_reg_r <= wd[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_tmp_r <= bit_exec_pkg::IO_RST;
    end else if (exec_now && io_op && io_in_range) begin
      io_tmp_r <= io_r[cmd_r.io_addr];
    end
  end

  for (genvar gi = 0; gi < IO_REGS; gi++) begin : g_io
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        io_r[gi] <= bit_exec_pkg::IO_RST;
      end else if (state_r == bit_exec_pkg::st_io_write && 32'(cmd_r.io_addr) == gi) begin
        io_r[gi] <= io_mod;
      end else if (wr_ok && wr_io && 32'(wr_idx) == gi) begin
        io_r[gi] <= wd[7:0];
      end
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign status_flags = status_flags_reg_r;
  assign busy = busy_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_lsl_result: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::logical_left_shift_op
    |=> dest_r == {$past(dest_r[6:0]), 1'b0})
    else $error("left shift result wrong");

  a_lsr_result: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::logical_right_shift_op
    |=> dest_r == {1'b0, $past(dest_r[7:1])})
    else $error("right shift result wrong");

  a_rol_carry: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::rotate_left_carry_op
    |=> dest_r == {$past(dest_r[6:0]), $past(status_flags_reg_r[0])}
        && status_flags_reg_r[0] == $past(dest_r[7]))
    else $error("rotate left wrong");

  a_ror_carry: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::rotate_right_carry_op
    |=> dest_r == {$past(status_flags_reg_r[0]), $past(dest_r[7:1])}
        && status_flags_reg_r[0] == $past(dest_r[0]))
    else $error("rotate right wrong");

  a_asr_sign: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::arith_right_shift_op
    |=> dest_r == {$past(dest_r[7]), $past(dest_r[7:1])})
    else $error("arithmetic shift wrong");

  a_swap_nibble: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::nibble_swap_op
    |=> dest_r == {$past(dest_r[3:0]), $past(dest_r[7:4])})
    else $error("nibble swap wrong");

  a_generic_flag: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::generic_flag_clear_op
    |=> status_flags_reg_r == ($past(status_flags_reg_r) & ~bit_mask))
    else $error("generic flag clear wrong");

  a_bit_store: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::bit_to_transfer_flag_op
    |=> status_flags_reg_r[6] == $past(source_reg_r[cmd_r.bit_idx]))
    else $error("bit store wrong");

  a_bit_load: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::transfer_flag_to_bit_op
    |=> (dest_r & ~bit_mask) == ($past(dest_r) & ~bit_mask)
        && dest_r[cmd_r.bit_idx] == $past(status_flags_reg_r[6]))
    else $error("bit load wrong");

  a_io_two_cycle: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::io_bit_set_op && io_in_range
    |-> busy_r ##1 busy_r ##1 (!busy_r
        && io_r[cmd_r.io_addr] == ($past(io_r[cmd_r.io_addr], 2) | bit_mask)))
    else $error("io bit set wrong");

  a_carry_only: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::carry_set_op
    |=> status_flags_reg_r == ($past(status_flags_reg_r) | 8'h01))
    else $error("carry set wrong");

  a_zero_single: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::zero_clear_op
    |=> !busy_r && status_flags_reg_r == ($past(status_flags_reg_r) & 8'hfd))
    else $error("zero clear wrong");

  a_irq_flag: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::irq_disable_op
    |=> status_flags_reg_r == ($past(status_flags_reg_r) & 8'h7f))
    else $error("interrupt disable wrong");

  a_overflow_flag: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::overflow_set_op
    |=> status_flags_reg_r == ($past(status_flags_reg_r) | 8'h08))
    else $error("overflow set wrong");

  a_transfer_flag: assert property (
    exec_now && cmd_r.op == bit_exec_pkg::transfer_flag_clear_op
    |=> status_flags_reg_r == ($past(status_flags_reg_r) & 8'hbf))
    else $error("transfer flag clear wrong");

endmodule : bit_shift_flag_exec_unit

// [verilog/flag_op_unit.sv]
// Purpose: Status flag set, clear and bit store
// Assumes: Pure combinational, result registered by the caller
// Notes: Each dedicated operation touches exactly one flag
`timescale 1ns/100ps
module flag_op_unit (
  input bit_exec_pkg::op_e op,
  input wire logic [2:0] bit_idx,
  input wire logic [7:0] src,
  input wire logic [7:0] flags_in,
  output logic [7:0] flags_out
);
  // ==========================================================
  // Flag updates
  always_comb begin
    flags_out = flags_in;
    case (op)
      bit_exec_pkg::generic_flag_set_op: flags_out[bit_idx] = 1'b1;
      bit_exec_pkg::generic_flag_clear_op: flags_out[bit_idx] = 1'b0;
      bit_exec_pkg::bit_to_transfer_flag_op: begin
        flags_out[bit_exec_pkg::FLAG_T] = src[bit_idx];
      end
      bit_exec_pkg::carry_set_op: flags_out[bit_exec_pkg::FLAG_C] = 1'b1;
      bit_exec_pkg::carry_clear_op: flags_out[bit_exec_pkg::FLAG_C] = 1'b0;
      bit_exec_pkg::negative_set_op: flags_out[bit_exec_pkg::FLAG_N] = 1'b1;
      bit_exec_pkg::negative_clear_op: flags_out[bit_exec_pkg::FLAG_N] = 1'b0;
      bit_exec_pkg::zero_set_op: flags_out[bit_exec_pkg::FLAG_Z] = 1'b1;
      bit_exec_pkg::zero_clear_op: flags_out[bit_exec_pkg::FLAG_Z] = 1'b0;
      bit_exec_pkg::irq_enable_op: flags_out[bit_exec_pkg::FLAG_I] = 1'b1;
      bit_exec_pkg::irq_disable_op: flags_out[bit_exec_pkg::FLAG_I] = 1'b0;
      bit_exec_pkg::signed_flag_set_op: flags_out[bit_exec_pkg::FLAG_S] = 1'b1;
      bit_exec_pkg::signed_flag_clear_op: flags_out[bit_exec_pkg::FLAG_S] = 1'b0;
      bit_exec_pkg::overflow_set_op: flags_out[bit_exec_pkg::FLAG_V] = 1'b1;
      bit_exec_pkg::overflow_clear_op: flags_out[bit_exec_pkg::FLAG_V] = 1'b0;
      bit_exec_pkg::transfer_flag_set_op: flags_out[bit_exec_pkg::FLAG_T] = 1'b1;
      bit_exec_pkg::transfer_flag_clear_op: flags_out[bit_exec_pkg::FLAG_T] = 1'b0;
      default: flags_out = flags_in;
    endcase
  end
endmodule : flag_op_unit

// [verilog/shift_rotate_unit.sv]
// Purpose: Shift, rotate, nibble swap and transfer-flag load on one byte
// Assumes: Pure combinational, result registered by the caller
// Notes: Unrelated operations pass operand and flags through
`timescale 1ns/100ps
module shift_rotate_unit (
  input bit_exec_pkg::op_e op,
  input wire logic [2:0] bit_idx,
  input wire logic [7:0] rd,
  input wire logic [7:0] flags_in,
  output logic [7:0] rd_out,
  output logic [7:0] flags_out
);
  // ==========================================================
  // Datapath
  always_comb begin
    rd_out = rd;
    flags_out = flags_in;
    case (op)
      bit_exec_pkg::logical_left_shift_op: begin
        rd_out = {rd[6:0], 1'b0};
        flags_out[bit_exec_pkg::FLAG_C] = rd[7];
      end
      bit_exec_pkg::logical_right_shift_op: begin
        rd_out = {1'b0, rd[7:1]};
        flags_out[bit_exec_pkg::FLAG_C] = rd[0];
      end
      bit_exec_pkg::rotate_left_carry_op: begin
        rd_out = {rd[6:0], flags_in[bit_exec_pkg::FLAG_C]};
        flags_out[bit_exec_pkg::FLAG_C] = rd[7];
      end
      bit_exec_pkg::rotate_right_carry_op: begin
        rd_out = {flags_in[bit_exec_pkg::FLAG_C], rd[7:1]};
        flags_out[bit_exec_pkg::FLAG_C] = rd[0];
      end
      bit_exec_pkg::arith_right_shift_op: begin
        rd_out = {rd[7], rd[7:1]};
        flags_out[bit_exec_pkg::FLAG_C] = rd[0];
      end
      bit_exec_pkg::nibble_swap_op: begin
        rd_out = {rd[3:0], rd[7:4]};
      end
      bit_exec_pkg::transfer_flag_to_bit_op: begin
        rd_out[bit_idx] = flags_in[bit_exec_pkg::FLAG_T];
      end
      default: begin
        rd_out = rd;
      end
    endcase
  end
endmodule : shift_rotate_unit
